// [isc_params.svh]
// constants for the infeed sequence control block
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH
`define ISC_CLK_HZ        10000000
`define ISC_TICK_US       1000
`define ISC_HARM_N        8
`define ISC_ADR_CTRL      8'h00
`define ISC_ADR_STATUS    8'h04
`define ISC_ADR_CWDISP    8'h08
`define ISC_ADR_MISSING   8'h0c
`define ISC_ADR_FAULTW    8'h10
`define ISC_ADR_OFFDLY    8'h14
`define ISC_ADR_REACTFIX  8'h18
`define ISC_ADR_IMAX      8'h1c
`define ISC_ADR_REACT     8'h20
`define ISC_ADR_HARM      8'h24
`define ISC_CTRL_BUSMODE  16
`define ISC_CW_ON         0
`define ISC_CW_QS         1
`define ISC_CW_EN         3
`define ISC_CW_DMOT       5
`define ISC_CW_IREG       6
`define ISC_CW_ACK        7
`define ISC_CW_MST        10
`define ISC_SW_RDYON      0
`define ISC_SW_RDYOP      1
`define ISC_SW_RUN        2
`define ISC_SW_FAULT      3
`define ISC_SW_NOQS       4
`define ISC_SW_INH        6
`define ISC_SW_ALARM      7
`define ISC_SW_MST        9
`define ISC_SW_PRECH      11
`define ISC_SW_LCFB       12
`define ISC_ME_ON         0
`define ISC_ME_QS         1
`define ISC_ME_EN         3
`define ISC_ME_PE         4
`define ISC_OPD_WAITEN    8'h00
`define ISC_OPD_RUN       8'h01
`define ISC_OPD_INHIBIT   8'h10
`define ISC_OPD_READY     8'h11
`define ISC_OPD_PRECHG    8'h12
`define ISC_OPD_CLOSE     8'h13
`define ISC_OPD_OFFDLY    8'h14
`define ISC_OPD_OPEN      8'h15
`define ISC_RST_OFFDLY    16'h0000
`define ISC_RST_IMAX      16'h7fff
`define ISC_RST_CTRL      17'h00000
`endif

// [isc_pkg.sv]
// types of the infeed sequence control block
`include "isc_params.svh"
package isc_pkg;
  typedef enum logic [7:0] {
    ST_INHIBIT = 8'h01,
    ST_READY   = 8'h02,
    ST_PRECHG  = 8'h04,
    ST_CLOSE   = 8'h08,
    ST_RDYOP   = 8'h10,
    ST_RUN     = 8'h20,
    ST_OFFDLY  = 8'h40,
    ST_OPEN    = 8'h80
  } isc_state_e;

  typedef struct packed {
    logic on_cmd_source;
    logic quick_stop_source_a;
    logic quick_stop_source_b;
    logic enable_operation_source;
    logic disable_motoring_source;
    logic inhibit_regen_source;
    logic ack_source_a;
    logic ack_source_b;
    logic ack_source_c;
    logic master_ctrl_source;
    logic pulse_enable_terminal;
    logic precharge_done;
    logic contactor_fb;
    logic fault_cause;
    logic alarm_cause;
  } isc_pins_s;

  typedef struct packed {
    logic precharge_cmd;
    logic contactor_cmd;
    logic pulses_on;
    logic motoring_ok;
    logic regen_ok;
  } isc_power_s;

  typedef struct packed {
    isc_pins_s   sync1;
    isc_pins_s   sync2;
    logic        on_prev;
    logic        ack_prev;
    isc_state_e  st;
    logic [15:0] tick_cnt;
    logic [15:0] dly_cnt;
    logic        fault;
    logic [15:0] bus_cw;
    logic        bus_mode;
    logic [15:0] off_delay;
    logic [15:0] react_fix;
    logic [15:0] imax;
    logic [15:0] react_out;
    logic        inductive;
    logic [15:0] sword;
    logic        ack;
    logic [31:0] rdata;
    logic [2:0]  harm_idx;
    logic [2:0]  harm_idx_d;
    logic [7:0]  harm_order;
    logic [7:0]  harm_scale;
    logic        harm_valid;
    isc_power_s  power;
  } isc_main_s;
endpackage : isc_pkg

// [isc_harm_mem.sv]
// harmonic order and scaling table with registered read
`timescale 1ns/10ps
`include "isc_params.svh"
module isc_harm_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `ISC_HARM_N,
  parameter int AW    = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } isc_mem_s;

  isc_mem_s s_reg;
  isc_mem_s s_next;

  generate
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
      $error("isc_harm_mem: depth does not fit address width");
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    if (wr_en && int'(wr_addr) < DEPTH) begin
      s_next.mem[wr_addr] = wr_data;
    end
    s_next.rdata = (int'(rd_addr) < DEPTH) ? s_reg.mem[rd_addr] : '0;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rdata;
endmodule : isc_harm_mem

// [isc_infeed_seq.sv]
// infeed sequence control: power-up/down, words, reactive and harmonics
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "isc_params.svh"
module isc_infeed_seq #(
  parameter int TICK_CYC = `ISC_CLK_HZ / 1000000 * `ISC_TICK_US,
  parameter int HARM_N   = `ISC_HARM_N
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire isc_pkg::isc_pins_s pins,
  input  wire logic [15:0]        reactive_dynamic_setpoint,
  input  wire logic [15:0]        active_setpoint,
  output isc_pkg::isc_power_s     power,
  output logic      [15:0]        bus_status_word,
  output logic      [15:0]        reactive_setpoint_display,
  output logic                    reactive_inductive,
  output logic      [2:0]         harm_index,
  output logic      [7:0]         harm_order,
  output logic      [7:0]         harm_scale,
  output logic                    harm_valid
);
  isc_pkg::isc_main_s s_reg;
  isc_pkg::isc_main_s s_next;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  localparam logic [2:0]  HARM_LAST = 3'(HARM_N - 1);

  generate
    if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_tick_chk
      $error("isc_infeed_seq: TICK_CYC out of range");
    end
    if (HARM_N < 2 || HARM_N > 8) begin : g_harm_chk
      $error("isc_infeed_seq: HARM_N must be 2 to 8");
    end
  endgenerate

  logic        qs_ok;
  logic        on_rise;
  logic        ack_lvl;
  logic        ack_rise;
  logic        tick;
  logic        req;
  logic        wr_take;
  logic        harm_we;
  logic [15:0] cw;
  logic [15:0] cw_disp;
  logic [15:0] fa_ctrl;
  logic [15:0] fa_stat;
  logic [15:0] miss;
  logic [15:0] sw;
  logic [7:0]  opd;
  logic [15:0] mem_rd;
  logic [15:0] act_abs;
  logic signed [16:0] sum;
  logic signed [16:0] lim;
  logic signed [16:0] rq;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  isc_harm_mem #(
    .WIDTH (16),
    .DEPTH (HARM_N),
    .AW    (3)
  ) u_harm (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (harm_we),
    .wr_addr (avs_writedata[18:16]),
    .wr_data (avs_writedata[15:0]),
    .rd_addr (s_reg.harm_idx),
    .rd_data (mem_rd)
  );

  always_comb begin
    s_next = s_reg;
    // only the second stage is read by logic
    s_next.sync1 = pins;
    s_next.sync2 = s_reg.sync1;

    // control word from terminals or from the bus
    cw = '0;
    if (s_reg.bus_mode) begin
      cw[`ISC_CW_ON]   = s_reg.bus_cw[`ISC_CW_ON];
      cw[`ISC_CW_QS]   = s_reg.bus_cw[`ISC_CW_QS];
      cw[`ISC_CW_EN]   = s_reg.bus_cw[`ISC_CW_EN];
      cw[`ISC_CW_DMOT] = s_reg.bus_cw[`ISC_CW_DMOT];
      cw[`ISC_CW_IREG] = s_reg.bus_cw[`ISC_CW_IREG];
      cw[`ISC_CW_ACK]  = s_reg.bus_cw[`ISC_CW_ACK];
      cw[`ISC_CW_MST]  = s_reg.bus_cw[`ISC_CW_MST];
    end else begin
      cw[`ISC_CW_ON]   = s_reg.sync2.on_cmd_source;
      cw[`ISC_CW_QS]   = s_reg.sync2.quick_stop_source_a
                         & s_reg.sync2.quick_stop_source_b;
      cw[`ISC_CW_EN]   = s_reg.sync2.enable_operation_source;
      cw[`ISC_CW_DMOT] = s_reg.sync2.disable_motoring_source;
      cw[`ISC_CW_IREG] = s_reg.sync2.inhibit_regen_source;
      cw[`ISC_CW_ACK]  = s_reg.sync2.ack_source_a | s_reg.sync2.ack_source_b
                         | s_reg.sync2.ack_source_c;
      cw[`ISC_CW_MST]  = s_reg.sync2.master_ctrl_source;
    end
    cw_disp = cw;
    cw_disp[`ISC_CW_ACK] = 1'b0;
    fa_ctrl = '0;
    fa_ctrl[`ISC_CW_ACK] = cw[`ISC_CW_ACK];

    qs_ok    = cw[`ISC_CW_QS];
    ack_lvl  = cw[`ISC_CW_ACK];
    on_rise  = cw[`ISC_CW_ON] & ~s_reg.on_prev;
    ack_rise = ack_lvl & ~s_reg.ack_prev;
    s_next.on_prev  = cw[`ISC_CW_ON];
    s_next.ack_prev = ack_lvl;

    // fault latch: a new cause wins over the acknowledge
    s_next.fault = s_reg.sync2.fault_cause | (s_reg.fault & ~ack_rise);

    // millisecond enable for the off delay
    tick = (s_reg.tick_cnt == TICK_LAST);
    s_next.tick_cnt = tick ? 16'h0000 : s_reg.tick_cnt + 16'h0001;

    // sequencer
    case (s_reg.st)
      isc_pkg::ST_INHIBIT: begin
        if (!cw[`ISC_CW_ON] && qs_ok && !s_reg.fault) begin
          s_next.st = isc_pkg::ST_READY;
        end
      end
      isc_pkg::ST_READY: begin
        if (!qs_ok || s_reg.fault) begin
          s_next.st = isc_pkg::ST_INHIBIT;
        end else if (on_rise && s_reg.sync2.pulse_enable_terminal) begin
          s_next.st = isc_pkg::ST_PRECHG;
        end
      end
      isc_pkg::ST_PRECHG: begin
        if (!qs_ok || s_reg.fault || !cw[`ISC_CW_ON]) begin
          s_next.st = isc_pkg::ST_OPEN;
        end else if (s_reg.sync2.precharge_done) begin
          s_next.st = isc_pkg::ST_CLOSE;
        end
      end
      isc_pkg::ST_CLOSE: begin
        if (!qs_ok || s_reg.fault || !cw[`ISC_CW_ON]) begin
          s_next.st = isc_pkg::ST_OPEN;
        end else if (s_reg.sync2.contactor_fb) begin
          s_next.st = isc_pkg::ST_RDYOP;
        end
      end
      isc_pkg::ST_RDYOP: begin
        if (!qs_ok || s_reg.fault || !cw[`ISC_CW_ON]) begin
          s_next.st = isc_pkg::ST_OPEN;
        end else if (cw[`ISC_CW_EN]) begin
          s_next.st = isc_pkg::ST_RUN;
        end
      end
      isc_pkg::ST_RUN: begin
        s_next.dly_cnt = 16'h0000;
        if (!qs_ok || s_reg.fault) begin
          s_next.st = isc_pkg::ST_OPEN;
        end else if (!cw[`ISC_CW_ON]) begin
          s_next.st = isc_pkg::ST_OFFDLY;
        end else if (!cw[`ISC_CW_EN]) begin
          s_next.st = isc_pkg::ST_RDYOP;
        end
      end
      isc_pkg::ST_OFFDLY: begin
        // drives brake meanwhile; pulse inhibit on them is the controller's job
        if (tick) begin
          s_next.dly_cnt = s_reg.dly_cnt + 16'h0001;
        end
        if (!qs_ok || s_reg.fault || !cw[`ISC_CW_EN]) begin
          s_next.st = isc_pkg::ST_OPEN;
        end else if (cw[`ISC_CW_ON]) begin
          s_next.st = isc_pkg::ST_RUN;
        end else if (s_reg.dly_cnt >= s_reg.off_delay) begin
          s_next.st = isc_pkg::ST_OPEN;
        end
      end
      isc_pkg::ST_OPEN: begin
        // reverse order: controller off, contactor opened, no precharge
        if (!s_reg.sync2.contactor_fb) begin
          s_next.st = isc_pkg::ST_INHIBIT;
        end
      end
      default: begin
        s_next.st = isc_pkg::ST_INHIBIT;
      end
    endcase

    s_next.power.precharge_cmd = (s_next.st == isc_pkg::ST_PRECHG);
    s_next.power.contactor_cmd = (s_next.st == isc_pkg::ST_CLOSE)
                                 | (s_next.st == isc_pkg::ST_RDYOP)
                                 | (s_next.st == isc_pkg::ST_RUN)
                                 | (s_next.st == isc_pkg::ST_OFFDLY);
    s_next.power.pulses_on     = (s_next.st == isc_pkg::ST_RUN)
                                 | (s_next.st == isc_pkg::ST_OFFDLY);
    s_next.power.motoring_ok   = s_next.power.pulses_on & ~cw[`ISC_CW_DMOT];
    s_next.power.regen_ok      = s_next.power.pulses_on & ~cw[`ISC_CW_IREG];

    // status word
    sw = '0;
    sw[`ISC_SW_RDYON] = (s_reg.st != isc_pkg::ST_INHIBIT)
                        & (s_reg.st != isc_pkg::ST_OPEN);
    sw[`ISC_SW_RDYOP] = (s_reg.st == isc_pkg::ST_RDYOP) | s_reg.power.pulses_on;
    sw[`ISC_SW_RUN]   = s_reg.power.pulses_on;
    sw[`ISC_SW_FAULT] = s_reg.fault;
    sw[`ISC_SW_NOQS]  = qs_ok;
    sw[`ISC_SW_INH]   = (s_reg.st == isc_pkg::ST_INHIBIT);
    sw[`ISC_SW_ALARM] = s_reg.sync2.alarm_cause;
    sw[`ISC_SW_MST]   = cw[`ISC_CW_MST];
    sw[`ISC_SW_PRECH] = s_reg.sync2.precharge_done;
    sw[`ISC_SW_LCFB]  = s_reg.sync2.contactor_fb;
    s_next.sword = sw;
    fa_stat = '0;
    fa_stat[`ISC_SW_FAULT] = s_reg.sword[`ISC_SW_FAULT];
    fa_stat[`ISC_SW_ALARM] = s_reg.sword[`ISC_SW_ALARM];

    case (s_reg.st)
      isc_pkg::ST_INHIBIT: opd = `ISC_OPD_INHIBIT;
      isc_pkg::ST_READY:   opd = `ISC_OPD_READY;
      isc_pkg::ST_PRECHG:  opd = `ISC_OPD_PRECHG;
      isc_pkg::ST_CLOSE:   opd = `ISC_OPD_CLOSE;
      isc_pkg::ST_RDYOP:   opd = `ISC_OPD_WAITEN;
      isc_pkg::ST_RUN:     opd = `ISC_OPD_RUN;
      isc_pkg::ST_OFFDLY:  opd = `ISC_OPD_OFFDLY;
      default:             opd = `ISC_OPD_OPEN;
    endcase
    miss = '0;
    if (opd == `ISC_OPD_WAITEN) begin
      miss[`ISC_ME_ON] = ~cw[`ISC_CW_ON];
      miss[`ISC_ME_QS] = ~qs_ok;
      miss[`ISC_ME_EN] = ~cw[`ISC_CW_EN];
      miss[`ISC_ME_PE] = ~s_reg.sync2.pulse_enable_terminal;
    end

    // reactive current: sum, sign as type, limit by the remaining headroom
    sum = signed'({s_reg.react_fix[15], s_reg.react_fix})
          + signed'({reactive_dynamic_setpoint[15], reactive_dynamic_setpoint});
    act_abs = active_setpoint[15] ? 16'(-active_setpoint) : active_setpoint;
    lim = signed'({1'b0, s_reg.imax}) - signed'({1'b0, act_abs});
    if (lim < 0) begin
      lim = '0;
    end
    if (sum > lim) begin
      rq = lim;
    end else if (sum < -lim) begin
      rq = -lim;
    end else begin
      rq = sum;
    end
    s_next.react_out = rq[15:0];
    s_next.inductive = rq < 0;

    // harmonic scan, one entry per cycle; order zero marks an empty slot
    s_next.harm_idx   = (s_reg.harm_idx == HARM_LAST) ? 3'h0 : s_reg.harm_idx + 3'h1;
    // table read takes two stages, so the shown index trails the scan by two
    s_next.harm_idx_d = (s_reg.harm_idx == 3'h0) ? HARM_LAST : s_reg.harm_idx - 3'h1;
    s_next.harm_order = mem_rd[7:0];
    s_next.harm_scale = mem_rd[15:8];
    s_next.harm_valid = (mem_rd[7:0] != 8'h00);

    // avalon slave: one wait state, read data loaded on the first edge
    req      = avs_read | avs_write;
    s_next.ack = req & ~s_reg.ack;
    wr_take  = avs_write & s_reg.ack;
    harm_we  = wr_take && avs_address == `ISC_ADR_HARM && avs_byteenable == 4'hf;
    if (avs_read && !s_reg.ack) begin
      case (avs_address)
        `ISC_ADR_CTRL:     s_next.rdata = {15'h0000, s_reg.bus_mode, s_reg.bus_cw};
        `ISC_ADR_STATUS:   s_next.rdata = {8'h00, opd, s_reg.sword};
        `ISC_ADR_CWDISP:   s_next.rdata = {16'h0000, cw_disp};
        `ISC_ADR_MISSING:  s_next.rdata = {16'h0000, miss};
        `ISC_ADR_FAULTW:   s_next.rdata = {fa_stat, fa_ctrl};
        `ISC_ADR_OFFDLY:   s_next.rdata = {16'h0000, s_reg.off_delay};
        `ISC_ADR_REACTFIX: s_next.rdata = {16'h0000, s_reg.react_fix};
        `ISC_ADR_IMAX:     s_next.rdata = {16'h0000, s_reg.imax};
        `ISC_ADR_REACT:    s_next.rdata = {15'h0000, s_reg.inductive, s_reg.react_out};
        default:           s_next.rdata = 32'h00000000;
      endcase
    end
    if (wr_take) begin
      case (avs_address)
        `ISC_ADR_CTRL: begin
          {s_next.bus_mode, s_next.bus_cw} = 17'(merge({15'h0000, s_reg.bus_mode,
                                      s_reg.bus_cw}, avs_writedata, avs_byteenable));
        end
        `ISC_ADR_OFFDLY: begin
          s_next.off_delay = 16'(merge({16'h0000, s_reg.off_delay}, avs_writedata,
                                       avs_byteenable));
        end
        `ISC_ADR_REACTFIX: begin
          s_next.react_fix = 16'(merge({16'h0000, s_reg.react_fix}, avs_writedata,
                                       avs_byteenable));
        end
        `ISC_ADR_IMAX: begin
          // top bit held low so the limit always fits a signed word
          s_next.imax = 16'(merge({16'h0000, s_reg.imax}, avs_writedata,
                                  avs_byteenable)) & 16'h7fff;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg           <= '0;
      s_reg.st        <= isc_pkg::ST_INHIBIT;
      s_reg.off_delay <= `ISC_RST_OFFDLY;
      s_reg.imax      <= `ISC_RST_IMAX;
      {s_reg.bus_mode, s_reg.bus_cw} <= `ISC_RST_CTRL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_waitrequest           = req & ~s_reg.ack;
  assign avs_readdata              = s_reg.rdata;
  assign power                     = s_reg.power;
  assign bus_status_word           = s_reg.sword;
  assign reactive_setpoint_display = s_reg.react_out;
  assign reactive_inductive        = s_reg.inductive;
  assign harm_index                = s_reg.harm_idx_d;
  assign harm_order                = s_reg.harm_order;
  assign harm_scale                = s_reg.harm_scale;
  assign harm_valid                = s_reg.harm_valid;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seq_run_off;
    s_reg.st == isc_pkg::ST_RUN && !cw[`ISC_CW_ON] && qs_ok && !s_reg.fault;
  endsequence
  sequence seq_going_down;
    s_reg.st == isc_pkg::ST_OFFDLY ##1 s_reg.st == isc_pkg::ST_OPEN;
  endsequence

  AST_ACK_LEVEL: assert property (
    s_reg.fault && ack_lvl && s_reg.ack_prev |=> s_reg.fault)
    else $error("held acknowledge cleared a fault");
  AST_ACK_EDGE: assert property (
    s_reg.fault && ack_rise && !s_reg.sync2.fault_cause |=> !s_reg.fault)
    else $error("acknowledge edge did not clear fault");
  AST_POWER_UP: assert property (
    s_reg.st == isc_pkg::ST_READY && on_rise && qs_ok && !s_reg.fault
    && s_reg.sync2.pulse_enable_terminal |=> s_reg.st == isc_pkg::ST_PRECHG
    ##0 s_reg.power.precharge_cmd)
    else $error("power-up did not start precharge");
  AST_REVERSE: assert property (
    seq_run_off |=> s_reg.st == isc_pkg::ST_OFFDLY && s_reg.power.contactor_cmd)
    else $error("switch-off did not enter off delay");
  AST_NO_PRECHG: assert property (
    seq_going_down |-> !s_reg.power.precharge_cmd [*2])
    else $error("precharge during power-down");
  AST_OFF_DELAY: assert property (
    s_reg.st == isc_pkg::ST_OFFDLY && s_reg.dly_cnt < s_reg.off_delay && !cw[`ISC_CW_ON]
    && qs_ok && cw[`ISC_CW_EN] && !s_reg.fault |=> s_reg.power.pulses_on)
    else $error("controller off before delay ran out");
  AST_MISSING: assert property (
    s_reg.st != isc_pkg::ST_RDYOP |-> miss == 16'h0000)
    else $error("missing enables shown outside waiting state");
  AST_QS_AND: assert property (
    !s_reg.bus_mode && !s_reg.sync2.quick_stop_source_b |=> !s_reg.sword[`ISC_SW_NOQS])
    else $error("quick stop source b ignored");
  AST_REGEN: assert property (
    cw[`ISC_CW_IREG] && $stable(cw) |=> !s_reg.power.regen_ok)
    else $error("regeneration not inhibited");
  AST_STATUS_RUN: assert property (
    s_reg.st == isc_pkg::ST_RUN |=> s_reg.sword[`ISC_SW_RUN] && s_reg.sword[`ISC_SW_RDYOP])
    else $error("status does not show operation enabled");
  AST_FAULT_BIT: assert property (
    s_reg.fault |=> s_reg.sword[`ISC_SW_FAULT] && fa_stat[`ISC_SW_FAULT])
    else $error("fault bit not reported");
  AST_REACT_LIM: assert property (
    1'b1 |=> ($signed(s_reg.react_out) <= $past(lim))
             && ($signed(s_reg.react_out) >= -$past(lim)))
    else $error("reactive setpoint beyond limit");
  AST_HARM: assert property (
    s_reg.harm_valid |-> s_reg.harm_order != 8'h00)
    else $error("empty harmonic slot marked valid");
endmodule : isc_infeed_seq

// [isc_plant_model.sv]
// plant model: link charge and contactor feedback follow the commands
`timescale 1ns/10ps
module isc_plant_model (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire isc_pkg::isc_power_s power,
  output logic                     precharge_done,
  output logic                     contactor_fb
);
  // one cycle of lag; a charged link stays charged while the contactor holds
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) {precharge_done, contactor_fb} <= 2'h0;
    else {precharge_done, contactor_fb} <=
      {power.precharge_cmd | power.contactor_cmd, power.contactor_cmd};
endmodule : isc_plant_model

// [isc_infeed_seq_tb_top.sv]
// bench for the infeed sequence control block
`timescale 1ns/10ps
module isc_infeed_seq_tb_top;
  logic                clk_sys = 1'b0, rst_n = 1'b0, rd_q = 1'b0, wr_q = 1'b0;
  logic                wreq, wait_s, pre_ok, lc_fb, bad;
  logic [7:0]          adr = 8'h00;
  logic [31:0]         wdat = 32'h0, rdat, rd;
  logic [15:0]         dyn = 16'h0, act = 16'h0, sw;
  logic [15:0]         r_disp;
  logic                r_ind, h_ok;
  logic [7:0]          h_or, h_sc;
  logic [2:0]          h_idx;
  isc_pkg::isc_pins_s  pd_drv = 15'h0, pins;
  isc_pkg::isc_power_s power;
  int                  n_mismatch = 0, n_checks = 0, cnt;
  isc_infeed_seq #(.TICK_CYC(10)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wdat), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .pins(pins), .reactive_dynamic_setpoint(dyn),
    .active_setpoint(act), .power(power), .bus_status_word(sw),
    .reactive_setpoint_display(r_disp), .reactive_inductive(r_ind), .harm_index(h_idx),
    .harm_order(h_or), .harm_scale(h_sc), .harm_valid(h_ok));
  isc_plant_model i_plant (.clk_sys(clk_sys), .rst_n(rst_n), .power(power),
    .precharge_done(pre_ok), .contactor_fb(lc_fb));
  initial forever #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys) wait_s = wreq; // combinational, so take it settled
  assign pins = {pd_drv[14:4], pre_ok, lc_fb, pd_drv[1:0]};
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) n_mismatch++;
    if (s !== e) $display("[ERR] %s exp %h seen %h", nm, e, s);
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {adr, wdat, wr_q, rd_q} <= {a, d, w, ~w};
    do @(posedge clk_sys); while (wait_s !== 1'b0);
    rd = rdat;
    {rd_q, wr_q} <= 2'h0;
  endtask : bus
  task ps(input isc_pkg::isc_pins_s v);
    @(posedge clk_sys) pd_drv <= v;
    repeat (5) @(negedge clk_sys);
  endtask : ps
  task t_words;
    chk("rst", {power, sw[6], sw[4]}, 7'h02);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmap", rd, 32'h0);
    ps(15'h3531);
    bus(1'b0, 8'h08, 32'h0);
    chk("cw", rd, 32'h0422);
    bus(1'b0, 8'h10, 32'h0);
    chk("faw", {sw[9], sw[7], sw[4], rd[28:0]}, 32'he0800080);
    $display("t_words done");
  endtask : t_words
  task rx(input logic [15:0] a, input logic [15:0] d, input logic [31:0] e);
    @(posedge clk_sys) {act, dyn} <= {a, d};
    repeat (4) @(negedge clk_sys);
    bus(1'b0, 8'h20, 32'h0);
    chk("react", rd, e);
    chk("rdisp", {r_ind, r_disp}, e);
  endtask : rx
  task t_react;
    bus(1'b1, 8'h18, 32'h0100);
    rx(16'h0000, 16'hfe00, 32'h0001ff00);
    rx(16'h7f80, 16'h0000, 32'h0000007f);
    $display("t_react done");
  endtask : t_react
  task t_up;
    bus(1'b1, 8'h14, 32'h0002);
    @(posedge clk_sys) pd_drv <= 15'h7010;
    for (cnt = 0; cnt < 40 && sw[1] !== 1'b1; cnt++) @(negedge clk_sys);
    chk("rdyop", {sw[12:11], sw[1]}, 3'h7);
    bus(1'b0, 8'h0c, 32'h0);
    chk("miss", rd, 32'h0008);
    ps(15'h7810);
    chk("run", {sw[2], power[2:0]}, 4'hf);
    ps(15'h7a10);
    chk("regen", power.regen_ok, 1'b0);
    $display("t_up done");
  endtask : t_up
  task t_down;
    bad = 1'b0;
    cnt = 0;
    @(posedge clk_sys) pd_drv <= 15'h3a10; // no drive pulses left on the link
    // pulses must drop no later than the contactor opens, with no precharge on the way
    repeat (60) begin
      @(negedge clk_sys);
      cnt += power.pulses_on;
      bad |= power.precharge_cmd | (power.pulses_on & ~power.contactor_cmd);
    end
    chk("dly", cnt >= 10 && cnt <= 34, 1'b1);
    chk("rev", {bad, power}, 6'h00);
    $display("t_down done");
  endtask : t_down
  task t_fault;
    ps(15'h3a12);
    chk("flt", sw[3], 1'b1);
    ps(15'h3a52);
    ps(15'h3a50);
    chk("lvl", sw[3], 1'b1);
    ps(15'h3a10);
    ps(15'h3a50);
    chk("ack", sw[3], 1'b0);
    $display("t_fault done");
  endtask : t_fault
  task t_bus;
    bus(1'b1, 8'h00, 32'h000104a2);
    bus(1'b0, 8'h08, 32'h0);
    chk("bcw", rd, 32'h00000422);
    bus(1'b0, 8'h10, 32'h0);
    chk("bfaw", rd, 32'h00000080);
    bus(1'b0, 8'h04, 32'h0);
    chk("bstat", rd, 32'h00110211);
    bus(1'b0, 8'h00, 32'h0);
    chk("bctrl", rd, 32'h000104a2);
    $display("t_bus done");
  endtask : t_bus
  task t_harm;
    bus(1'b1, 8'h24, 32'h00006405);
    bus(1'b1, 8'h24, 32'h00016407);
    repeat (4) @(negedge clk_sys);
    for (cnt = 0; cnt < 8; cnt++) begin
      @(negedge clk_sys);
      if (h_idx == 3'h0) chk("harm0", {h_ok, h_sc, h_or}, 32'h00016405);
      if (h_idx == 3'h1) chk("harm1", {h_ok, h_sc, h_or}, 32'h00016407);
      if (h_idx == 3'h2) chk("harm2", {h_ok, h_sc, h_or}, 32'h00000000);
    end
    $display("t_harm done");
  endtask : t_harm
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(negedge clk_sys);
    t_words;
    t_react;
    t_up;
    t_down;
    t_fault;
    t_bus;
    t_harm;
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    end_sim;
  end
endmodule : isc_infeed_seq_tb_top
